// ==== rtl/lpws_pkg.sv ====
`default_nettype none

package lpws_pkg;

	// ---------------------------------------------------------------
	// standby configuration word layout
	// ---------------------------------------------------------------
	localparam int CFG_W = 16;
	localparam int CFG_RSVD_LSB = 10;
	localparam int CFG_WAKE_OUT_BIT = 9;
	localparam int CFG_TIMER_WAKE_BIT = 8;
	localparam int CFG_EDGE_SEL_LSB = 6;
	localparam int CFG_THR2_LSB = 4;
	localparam int CFG_THR1_LSB = 2;
	localparam int CFG_THR0_LSB = 0;
	localparam int THR_CHANNELS = 3;

	// ---------------------------------------------------------------
	// field encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [1:0] THR_OFF = 2'h0;
	localparam logic [1:0] THR_ABOVE = 2'h1;
	localparam logic [1:0] THR_BELOW = 2'h2;

	// host command word that sends the device to sleep
	localparam logic [15:0] GO_SLEEP_WORD = 16'ha55a;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SLEEP_TICK_NS = 1000;
	localparam int INIT_TIME_NS = 2000;
	localparam int TICK_CYCLES = (SLEEP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);
	localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);

	// ---------------------------------------------------------------
	// modes and sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		LPWS_MODE_APP = 3'h0,
		LPWS_MODE_HOST = 3'h1,
		LPWS_MODE_TIMER = 3'h2,
		LPWS_MODE_THRESH = 3'h3,
		LPWS_MODE_COMB = 3'h4
	} lpws_mode_e;

	typedef enum logic [2:0] {
		LPWS_ST_APP = 3'h0,
		LPWS_ST_SLEEP = 3'h1,
		LPWS_ST_INIT = 3'h3,
		LPWS_ST_ACTIVE = 3'h2,
		LPWS_ST_EVAL = 3'h6
	} lpws_state_e;

endpackage

`default_nettype wire

// ==== rtl/lpws_thr_cmp.sv ====
`default_nettype none

module lpws_thr_cmp
	import lpws_pkg::*;
(
	input wire logic [1:0] thr_mode,
	input wire logic [15:0] meas,
	input wire logic [15:0] thr,
	output logic hit
);

	// -----------------------------------------------------------------
	// one threshold channel: above or below, reserved code never hits
	// -----------------------------------------------------------------
	always_comb begin
		case (thr_mode)
			THR_ABOVE: hit = (meas > thr);
			THR_BELOW: hit = (meas < thr);
			default: hit = 1'b0;
		endcase
	end

endmodule

`default_nettype wire

// ==== rtl/lpws_seq.sv ====
`default_nettype none

// What this block does
// - four low-power modes, each alternating a sleep phase and an active phase
// - outside low-power modes, run continuously in application mode, never sleeping
// - mode chosen from nonvolatile standby configuration bits
// - go-to-sleep word 0xA55A written to output channel three starts next sleep
// - host mode: sleep until host wake edge, then initialise and measure
// - host mode when edge select nonzero and all other bits zero
// - edge select decides which wake pin edges count as wake-up
// - timer modes: sleep for sleep_duration, then initialise and measure
// - timer indication mode: change wake pin level when active phase starts
// - timer indication mode when wake output and timer wake set, rest zero
// - threshold mode: compare each result against up to three thresholds
// - threshold mode: change wake pin only on a crossing, else sleep quietly
// - no threshold crossing after timer wake: return to sleep alone
// - threshold mode: timer, wake output, some threshold 01 or 10, rest zero
// - combined mode: timer, wake output, edge select and a threshold set
// - combined mode: wake by timer, host or both, measure normally
// - host wake edges count only in sleep phase, ignored when active
// - edge select: 00 off, 01 rising, 10 falling, 11 both
// - threshold field: 00 off, 01 above, 10 below, 11 reserved
// - new sample flag set on fresh sample, cleared when old sample resent
module lpws_seq
	import lpws_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] standby_config,
	input wire logic [15:0] sleep_duration,
	input wire logic [15:0] wake_threshold_value0,
	input wire logic [15:0] wake_threshold_value1,
	input wire logic [15:0] wake_threshold_value2,
	input wire logic [15:0] meas_value0,
	input wire logic [15:0] meas_value1,
	input wire logic [15:0] meas_value2,
	input wire logic meas_valid,
	input wire logic chan3_wr_en,
	input wire logic [15:0] chan3_wr_data,
	input wire logic sample_sent,
	input wire logic wake_io_pin_i,
	output logic wake_io_pin_o,
	output logic wake_io_pin_oe_n,
	output logic new_sample_flag,
	output logic sleep_phase,
	output logic active_phase,
	output logic meas_start,
	output logic [2:0] lp_mode
);

	// -----------------------------------------------------------------
	// configuration fields
	// -----------------------------------------------------------------
	logic wake_output_enable;
	logic timer_wake_enable;
	logic [1:0] external_wake_edge_sel;
	logic [1:0] thr_mode [THR_CHANNELS];
	logic rsvd_clear;

	assign wake_output_enable = standby_config[CFG_WAKE_OUT_BIT];
	assign timer_wake_enable = standby_config[CFG_TIMER_WAKE_BIT];
	assign external_wake_edge_sel = standby_config[CFG_EDGE_SEL_LSB +: 2];
	assign thr_mode[0] = standby_config[CFG_THR0_LSB +: 2];
	assign thr_mode[1] = standby_config[CFG_THR1_LSB +: 2];
	assign thr_mode[2] = standby_config[CFG_THR2_LSB +: 2];
	assign rsvd_clear = (standby_config[CFG_W-1:CFG_RSVD_LSB] == '0);

	// -----------------------------------------------------------------
	// mode decode
	// -----------------------------------------------------------------
	logic thr_any_valid;
	logic thr_any_rsvd;
	logic thr_all_off;
	lpws_mode_e mode;

	// at least one channel armed, none using the reserved code
	always_comb begin
		thr_any_valid = 1'b0;
		thr_any_rsvd = 1'b0;
		thr_all_off = 1'b1;
		for (int i = 0; i < THR_CHANNELS; i++) begin
			if (thr_mode[i] == THR_ABOVE || thr_mode[i] == THR_BELOW) begin
				thr_any_valid = 1'b1;
			end
			if (thr_mode[i] == 2'h3) begin
				thr_any_rsvd = 1'b1;
			end
			if (thr_mode[i] != THR_OFF) begin
				thr_all_off = 1'b0;
			end
		end
	end

	// any other combination falls back to continuous operation
	always_comb begin
		mode = LPWS_MODE_APP;
		if (rsvd_clear && !thr_any_rsvd) begin
			if (!wake_output_enable && !timer_wake_enable && external_wake_edge_sel != EDGE_NONE && thr_all_off) begin
				mode = LPWS_MODE_HOST;
			end else if (wake_output_enable && timer_wake_enable) begin
				if (external_wake_edge_sel == EDGE_NONE && thr_all_off) begin
					mode = LPWS_MODE_TIMER;
				end else if (external_wake_edge_sel == EDGE_NONE && thr_any_valid) begin
					mode = LPWS_MODE_THRESH;
				end else if (external_wake_edge_sel != EDGE_NONE && thr_any_valid) begin
					mode = LPWS_MODE_COMB;
				end
			end
		end
	end

	logic timer_mode;
	logic host_wake_mode;
	logic thresh_mode;

	assign timer_mode = (mode == LPWS_MODE_TIMER) || (mode == LPWS_MODE_THRESH) || (mode == LPWS_MODE_COMB);
	assign host_wake_mode = (mode == LPWS_MODE_HOST) || (mode == LPWS_MODE_COMB);
	assign thresh_mode = (mode == LPWS_MODE_THRESH) || (mode == LPWS_MODE_COMB);

	// -----------------------------------------------------------------
	// wake pin synchroniser and edge detection
	// -----------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;
	logic pin_prev_q;
	logic pin_rise;
	logic pin_fall;
	logic host_edge;

	// two flops, then a history flop for the edge detector
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= wake_io_pin_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pin_rise = pin_sync_q && !pin_prev_q;
	assign pin_fall = !pin_sync_q && pin_prev_q;

	// edge kind chosen by the edge select field
	always_comb begin
		case (external_wake_edge_sel)
			EDGE_RISE: host_edge = pin_rise;
			EDGE_FALL: host_edge = pin_fall;
			EDGE_BOTH: host_edge = pin_rise || pin_fall;
			default: host_edge = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------
	// threshold comparison
	// -----------------------------------------------------------------
	logic [THR_CHANNELS-1:0] thr_hit;

	lpws_thr_cmp u_thr0 (
		.thr_mode(thr_mode[0]),
		.meas(meas_value0),
		.thr(wake_threshold_value0),
		.hit(thr_hit[0])
	);

	lpws_thr_cmp u_thr1 (
		.thr_mode(thr_mode[1]),
		.meas(meas_value1),
		.thr(wake_threshold_value1),
		.hit(thr_hit[1])
	);

	lpws_thr_cmp u_thr2 (
		.thr_mode(thr_mode[2]),
		.meas(meas_value2),
		.thr(wake_threshold_value2),
		.hit(thr_hit[2])
	);

	// -----------------------------------------------------------------
	// sequencer state and counters
	// -----------------------------------------------------------------
	lpws_state_e state_q;
	lpws_state_e state_d;
	logic [CNT_W-1:0] tick_div_q;
	logic tick;
	logic [15:0] sleep_cnt_q;
	logic [CNT_W-1:0] init_cnt_q;
	logic woke_by_host_q;
	logic go_sleep;
	logic timer_expired;
	logic host_wake;
	logic init_done;

	// host command accepted only while awake in a low-power mode
	assign go_sleep = chan3_wr_en && (chan3_wr_data == GO_SLEEP_WORD)
		&& (state_q == LPWS_ST_ACTIVE || state_q == LPWS_ST_EVAL);
	assign timer_expired = timer_mode && (sleep_cnt_q == sleep_duration);
	assign host_wake = host_wake_mode && host_edge && (state_q == LPWS_ST_SLEEP);
	assign init_done = (init_cnt_q == INIT_LAST);
	assign tick = (tick_div_q == TICK_LAST);

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			LPWS_ST_APP: begin
				if (mode != LPWS_MODE_APP) begin
					state_d = LPWS_ST_INIT;
				end
			end
			LPWS_ST_SLEEP: begin
				if (host_wake || (state_q == LPWS_ST_SLEEP && timer_expired)) begin
					state_d = LPWS_ST_INIT;
				end
			end
			LPWS_ST_INIT: begin
				if (init_done) begin
					state_d = (thresh_mode && !woke_by_host_q) ? LPWS_ST_EVAL : LPWS_ST_ACTIVE;
				end
			end
			LPWS_ST_EVAL: begin
				if (go_sleep) begin
					state_d = LPWS_ST_SLEEP;
				end else if (meas_valid) begin
					state_d = (|thr_hit) ? LPWS_ST_ACTIVE : LPWS_ST_SLEEP;
				end
			end
			LPWS_ST_ACTIVE: begin
				if (go_sleep) begin
					state_d = LPWS_ST_SLEEP;
				end
			end
			default: state_d = LPWS_ST_APP;
		endcase
		if (mode == LPWS_MODE_APP) begin
			state_d = LPWS_ST_APP;
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= LPWS_ST_APP;
		end else begin
			state_q <= state_d;
		end
	end

	// sleep tick prescaler, runs only while asleep
	always_ff @(posedge sys_clk) begin
		if (rst || state_q != LPWS_ST_SLEEP || tick) begin
			tick_div_q <= '0;
		end else begin
			tick_div_q <= tick_div_q + CNT_W'(1);
		end
	end

	// sleep timer restarts from zero on every sleep entry
	always_ff @(posedge sys_clk) begin
		if (rst || state_q != LPWS_ST_SLEEP) begin
			sleep_cnt_q <= '0;
		end else if (tick && !timer_expired) begin
			sleep_cnt_q <= sleep_cnt_q + 16'h0001;
		end
	end

	// initialisation phase length
	always_ff @(posedge sys_clk) begin
		if (rst || state_q != LPWS_ST_INIT) begin
			init_cnt_q <= '0;
		end else if (!init_done) begin
			init_cnt_q <= init_cnt_q + CNT_W'(1);
		end
	end

	// a host wake skips the threshold check, also when a timer wake comes in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			woke_by_host_q <= 1'b0;
		end else if (state_q == LPWS_ST_SLEEP && state_d == LPWS_ST_INIT) begin
			woke_by_host_q <= host_wake;
		end
	end

	// -----------------------------------------------------------------
	// wake pin drive
	// -----------------------------------------------------------------
	logic indicate;

	// active phase start in timer mode, or a crossing in threshold evaluation
	assign indicate = ((mode == LPWS_MODE_TIMER) && state_q == LPWS_ST_INIT && init_done)
		|| (state_q == LPWS_ST_EVAL && !go_sleep && meas_valid && (|thr_hit));

	// level toggles on each indication
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_io_pin_o <= 1'b0;
		end else if (indicate && wake_output_enable) begin
			wake_io_pin_o <= !wake_io_pin_o;
		end
	end

	// released while asleep in combined mode so the host can drive edges
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_io_pin_oe_n <= 1'b1;
		end else begin
			wake_io_pin_oe_n <= !(wake_output_enable && timer_mode
				&& !(mode == LPWS_MODE_COMB && state_d == LPWS_ST_SLEEP));
		end
	end

	// -----------------------------------------------------------------
	// new sample flag
	// -----------------------------------------------------------------

	// a fresh sample wins over a resend in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			new_sample_flag <= 1'b0;
		end else if (meas_valid && state_q != LPWS_ST_SLEEP) begin
			new_sample_flag <= 1'b1;
		end else if (sample_sent) begin
			new_sample_flag <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// status outputs
	// -----------------------------------------------------------------

	// phase flags follow the next state so they line up with state_q
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sleep_phase <= 1'b0;
			active_phase <= 1'b0;
		end else begin
			sleep_phase <= (state_d == LPWS_ST_SLEEP);
			active_phase <= (state_d == LPWS_ST_ACTIVE) || (state_d == LPWS_ST_EVAL);
		end
	end

	// measurement request pulse at the end of initialisation
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meas_start <= 1'b0;
		end else begin
			meas_start <= (state_q == LPWS_ST_INIT) && init_done;
		end
	end

	// decoded mode, registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lp_mode <= LPWS_MODE_APP;
		end else begin
			lp_mode <= mode;
		end
	end

endmodule

`default_nettype wire

// ==== tb/lpws_chk.sv ====
`default_nettype none
// ------------
// sequencer port checker
// ------------
module lpws_chk
	import lpws_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] standby_config,
	input wire logic chan3_wr_en,
	input wire logic [15:0] chan3_wr_data,
	input wire logic meas_valid,
	input wire logic sample_sent,
	input wire logic wake_io_pin_i,
	input wire logic wake_io_pin_o,
	input wire logic wake_io_pin_oe_n,
	input wire logic new_sample_flag,
	input wire logic sleep_phase,
	input wire logic active_phase,
	input wire logic meas_start,
	input wire logic [2:0] lp_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic go;
	logic pin_q;
	logic [4:0] chg_q;
	assign go = chan3_wr_en && chan3_wr_data == GO_SLEEP_WORD;
	// recent changes of the wake line, used for the wake latency window
	always_ff @(posedge sys_clk) begin
		pin_q <= wake_io_pin_i;
		chg_q <= {chg_q[3:0], pin_q != wake_io_pin_i};
	end
	phase_excl_a: assert property (!(sleep_phase && active_phase))
		else $error("sleep and active phase together");
	rsvd_app_a: assert property (|standby_config[15:10] || standby_config[1:0] == 2'h3
		|| standby_config[3:2] == 2'h3 || standby_config[5:4] == 2'h3 |=> lp_mode == 3'h0)
		else $error("reserved configuration did not force application mode");
	app_awake_a: assert property (lp_mode == 3'h0 [*2] |-> !sleep_phase && !active_phase)
		else $error("phase flag set in application mode");
	go_sleep_a: assert property (active_phase && go && lp_mode != 3'h0 |=> sleep_phase)
		else $error("go-to-sleep word not obeyed");
	sleep_cause_a: assert property ($rose(sleep_phase) |-> $past(go) || $past(meas_valid))
		else $error("sleep entered without a cause");
	host_wake_a: assert property ($fell(sleep_phase) && lp_mode == 3'h1 |-> |chg_q)
		else $error("host mode woke without a fresh edge");
	timer_flag_a: assert property (lp_mode == 3'h2 && $rose(active_phase) |-> wake_io_pin_o != $past(wake_io_pin_o))
		else $error("active phase not indicated on wake line");
	quiet_sleep_a: assert property (lp_mode == 3'h3 && $rose(sleep_phase) |-> $stable(wake_io_pin_o))
		else $error("wake line changed on quiet return to sleep");
	drive_off_a: assert property (lp_mode <= 3'h1 [*2] |-> wake_io_pin_oe_n)
		else $error("wake line driven without wake output");
	start_pulse_a: assert property (meas_start |-> active_phase ##1 !meas_start)
		else $error("measurement start not a single pulse in active phase");
	flag_set_a: assert property (meas_valid && !sleep_phase |=> new_sample_flag)
		else $error("sample flag not set");
	flag_clr_a: assert property (sample_sent && !meas_valid |=> !new_sample_flag)
		else $error("sample flag not cleared");
	cover property (lp_mode == 3'h4 && $fell(sleep_phase));
	cover property (lp_mode == 3'h3 && $rose(sleep_phase));
	cover property (lp_mode == 3'h2 && $rose(active_phase));
endmodule
bind lpws_seq lpws_chk chk_i (.sys_clk(sys_clk), .rst(rst), .standby_config(standby_config),
	.chan3_wr_en(chan3_wr_en), .chan3_wr_data(chan3_wr_data), .meas_valid(meas_valid),
	.sample_sent(sample_sent), .wake_io_pin_i(wake_io_pin_i), .wake_io_pin_o(wake_io_pin_o),
	.wake_io_pin_oe_n(wake_io_pin_oe_n), .new_sample_flag(new_sample_flag), .sleep_phase(sleep_phase),
	.active_phase(active_phase), .meas_start(meas_start), .lp_mode(lp_mode));
`default_nettype wire

// ==== tb/lpws_host.sv ====
`default_nettype none
// ------------
// host controller model
// ------------
module lpws_host
	import lpws_pkg::*;
(
	input wire logic sys_clk,
	input wire logic flag,
	output logic pin,
	output logic wr_en,
	output logic [15:0] wr_data,
	output logic sent
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle levels at time zero
	initial begin
		pin = 1'b0;
		wr_en = 1'b0;
		wr_data = 16'h0000;
		sent = 1'b0;
	end
	// one level change of the wake line
	task automatic edge1();
		@(posedge sys_clk);
		pin <= ~pin;
	endtask
	// two edges so a combined-mode wake is never lost
	task automatic wake2();
		edge1();
		repeat (2) @(posedge sys_clk);
		edge1();
	endtask
	// one single-cycle write to channel three, data scrambled after release
	task automatic cmd(input logic [15:0] w);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		wr_data <= w;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		wr_data <= ~w;
	endtask
	// poll for a fresh sample, read it again, then send to sleep
	task automatic serve(output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 500 && !ok; i++) begin
			@(negedge sys_clk);
			ok = flag === 1'b1;
		end
		@(posedge sys_clk);
		sent <= 1'b1;
		@(posedge sys_clk);
		sent <= 1'b0;
		cmd(GO_SLEEP_WORD);
	endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench
	import lpws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, mv, sent, wr_en, hpin, pin_w, pin_o, oe_n, flag, slp, act, mst;
	logic [15:0] cfg, dur, wr_data, c;
	logic [15:0] mval [3];
	logic [15:0] tval [3];
	logic [15:0] tbl [8] = '{16'h0040, 16'h0080, 16'h00c0, 16'h0300, 16'h0400, 16'h03c1, 16'h0313, 16'h0302};
	logic [2:0] lp_mode;
	int errors, comparisons, n;
	bit ok, h, p;
	// wire level: device when it drives, host otherwise
	assign pin_w = oe_n ? hpin : pin_o;
	// system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	lpws_seq dut (.sys_clk(sys_clk), .rst(rst), .standby_config(cfg), .sleep_duration(dur),
		.wake_threshold_value0(tval[0]), .wake_threshold_value1(tval[1]), .wake_threshold_value2(tval[2]),
		.meas_value0(mval[0]), .meas_value1(mval[1]), .meas_value2(mval[2]), .meas_valid(mv),
		.chan3_wr_en(wr_en), .chan3_wr_data(wr_data), .sample_sent(sent), .wake_io_pin_i(pin_w),
		.wake_io_pin_o(pin_o), .wake_io_pin_oe_n(oe_n), .new_sample_flag(flag), .sleep_phase(slp),
		.active_phase(act), .meas_start(mst), .lp_mode(lp_mode));
	lpws_host host (.sys_clk(sys_clk), .flag(flag), .pin(hpin), .wr_en(wr_en), .wr_data(wr_data), .sent(sent));
	// ------------
	// reference model and helpers
	// ------------
	function automatic int mode_of(input logic [15:0] k);
		bit thr;
		thr = k[5:0] != 0;
		if (k[15:10] != 0 || k[1:0] == 3 || k[3:2] == 3 || k[5:4] == 3) return 0;
		if (k[9:8] == 0 && k[7:6] != 0 && !thr) return 1;
		if (k[9:8] == 3 && k[7:6] == 0) return thr ? 3 : 2;
		if (k[9:8] == 3 && thr) return 4;
		return 0;
	endfunction
	function automatic bit hit_of(input logic [15:0] k);
		bit r;
		r = 0;
		for (int j = 0; j < 3; j++)
			r |= (k[2*j+:2] == 1 && mval[j] > tval[j]) || (k[2*j+:2] == 2 && mval[j] < tval[j]);
		return r;
	endfunction
	function automatic bit near(input int want);
		return n >= want - 1 && n <= want + 3;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// bounded wait for a phase flag, n counts cycles
	task automatic wait_on(input bit on_act, input logic v);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
			if (n > 20000) begin
				errors++;
				$display("mismatch at %0t: wait ran out", $time);
				summarize();
			end
		end while ((on_act ? act : slp) !== v);
	endtask
	task automatic reset();
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
	endtask
	// one fresh random sample
	task automatic sample();
		@(posedge sys_clk);
		mv <= 1'b1;
		foreach (mval[j]) mval[j] <= 16'($urandom());
		@(posedge sys_clk);
		mv <= 1'b0;
	endtask
	// ------------
	// main sequence
	// ------------
	initial begin
		rst = 1'b1;
		{mv, cfg, dur} = '0;
		mval = '{default: 16'h0000};
		errors = 0;
		comparisons = 0;
		void'($urandom(6));
		foreach (tval[j]) tval[j] = 16'($urandom());
		reset();
		// mode decode, listed and random words
		for (int i = 0; i < 32; i++) begin
			c = i < 8 ? tbl[i] : 16'($urandom());
			if (i % 4 != 0) c[15:10] = 6'h00;
			@(posedge sys_clk);
			cfg <= c;
			repeat (2) @(negedge sys_clk);
			chk(16'(lp_mode), 16'(mode_of(c)));
		end
		// timer wake with indication
		@(posedge sys_clk);
		cfg <= 16'h0300;
		dur <= 16'h0002;
		reset();
		wait_on(1, 1);
		chk(16'({mst, pin_o, oe_n}), 16'h0006);
		host.cmd(16'h5aa5);
		repeat (3) @(negedge sys_clk);
		chk(16'(act), 16'h0001);
		sample();
		host.serve(ok);
		chk(16'(ok), 16'h0001);
		if (!ok) summarize();
		wait_on(0, 1);
		wait_on(0, 0);
		chk(16'(near(int'(dur) * TICK_CYCLES)), 16'h0001);
		wait_on(1, 1);
		chk(16'({mst, pin_o}), 16'h0002);
		// host wake for each edge selection
		for (int e = 1; e < 4; e++) begin
			@(posedge sys_clk);
			cfg <= 16'(e << 6);
			reset();
			wait_on(1, 1);
			host.edge1();
			repeat (6) @(negedge sys_clk);
			chk(16'({act, oe_n}), 16'h0003);
			if (e == 1 ? !hpin : e == 2 && hpin) host.edge1();
			repeat (6) @(negedge sys_clk);
			host.cmd(GO_SLEEP_WORD);
			wait_on(0, 1);
			if (e != 3) begin
				host.edge1();
				repeat (8) @(negedge sys_clk);
				chk(16'(slp), 16'h0001);
			end
			host.edge1();
			wait_on(0, 0);
			chk(16'(n <= 5), 16'h0001);
		end
		// threshold evaluation on random samples
		@(posedge sys_clk);
		cfg <= 16'h0301;
		dur <= 16'h0001;
		reset();
		p = 1'b0; // model of the driven wake level after reset
		for (int i = 0; i < 10; i++) begin
			wait_on(1, 1);
			c = 16'h0300;
			for (int j = 0; j < 3; j++) c[2*j+:2] = 2'($urandom_range(2));
			if (c[5:0] == 0) c[0] = 1'b1;
			@(posedge sys_clk);
			cfg <= c;
			sample();
			@(negedge sys_clk);
			h = hit_of(c);
			p = p ^ h;
			chk(16'({act, slp, pin_o, flag}), 16'({h, !h, p, 1'b1}));
			if (h) begin
				host.serve(ok);
				chk(16'(ok), 16'h0001);
				if (!ok) summarize();
			end
		end
		// combined mode: host wake, then timer wake
		if (hpin) host.edge1();
		@(posedge sys_clk);
		cfg <= 16'h03c1;
		dur <= 16'h0064;
		reset();
		wait_on(1, 1);
		host.cmd(GO_SLEEP_WORD);
		wait_on(0, 1);
		repeat (20) @(negedge sys_clk);
		chk(16'(oe_n), 16'h0001);
		host.wake2();
		wait_on(0, 0);
		chk(16'(n <= 5), 16'h0001);
		wait_on(1, 1);
		host.cmd(GO_SLEEP_WORD);
		wait_on(0, 1);
		wait_on(0, 0);
		chk(16'(near(int'(dur) * TICK_CYCLES)), 16'h0001);
		summarize();
	end
endmodule
`default_nettype wire
